// [inc/rect_ctl_consts.svh]
// timing counts, address constants and decode thresholds for the restart controller
`ifndef RECT_CTL_CONSTS_SVH
`define RECT_CTL_CONSTS_SVH
`define CLK_HZ            20000000
`define GRACE_S           20
`define RETRY_S           1
`define WINDOW_S          60
`define GRACE_CYC         (`GRACE_S * `CLK_HZ)
`define RETRY_CYC         (`RETRY_S * `CLK_HZ)
`define WINDOW_CYC        (`WINDOW_S * `CLK_HZ)
`define OV_LIMIT          2'd3
`define ADDR_UPPER        3'b100
`define ADDR_BCAST        7'h00
`define ADDR_ARA          7'h0c
`define LOW_VOUT_MV       16'd10000
`define BLINK_CYC         10000000
`define LVL_BITS          8
`endif

// [inc/rect_ctl_pkg.sv]
// shared types of the restart and address controller
package rect_ctl_pkg;
	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_ON      = 3'b001,
		ST_WAIT    = 3'b010,
		ST_LATCHED = 3'b011,
		ST_HICCUP  = 3'b100
	} run_state_t;

	// fault and limit status inputs grouped together
	typedef struct packed {
		logic ovp;
		logic ocp;
		logic otp;
		logic in_limit;
		logic overload;
	} fault_in_t;

	// bus transaction summary from the serial engine
	typedef struct packed {
		logic       valid;
		logic [6:0] addr;
		logic       rd;
		logic       op_write;
		logic       op_on;
		logic [6:0] ara_byte;
	} bus_req_t;

	typedef struct packed {
		run_state_t state;
		logic [31:0] timer;
		logic [31:0] window;
		logic [1:0]  ov_count;
		logic        grace_done;
		logic        last_fault_ov;
		logic        op_on;
		logic        op_was_off;
		logic        en_was_off;
		logic        alert;
		logic        invalid_cmd;
		logic [23:0] blink;
		logic        led;
		logic [1:0]  en_sync;
		logic [1:0]  slot_sync;
		logic [1:0]  proto_sync;
	} ctl_state_t;
endpackage

// [rtl/rect_restart_ctl.sv]
// restart sequencing, address decode and alert handling of the rectifier controller
//
// Behaviour
// - overload at power-up held in current limit for 20 s, then protection applies.
// - overvoltage restarts wait 1 s each; three failures inside a minute latch off.
// - fewer than three overvoltage trips in the minute clears the count.
// - overcurrent and overtemperature auto-restart unless latch-off is configured.
// - enable pin cycled off then on releases latch-off and restarts.
// - operation command off then on over the bus releases latch-off.
// - limit above 10 V blinks the output indicator; below 10 V restart hiccups.
// - indicator steady while on, off while output off or latched.
// - open protocol pin selects two-wire mode; 1k-5k to return selects RS485.
// - bus address is 100 followed by four position bits, 40 to 4F.
// - address lsb selects direction, 0 write and 1 read.
// - writes to broadcast address 00 are accepted and acted on while the unit's own address is valid.
// - reads to broadcast address are refused and flag invalid command.
// - status change pulls the shared alert line; alert-response address 0C recognised.
// - unit level quantised into ten positions, 3.30 V level invalid.
// - rack level quantised into eight positions from 3.3 V down to 0 V.
// - units 1-4 with racks 1-4 give (rack-1)*4 + (unit-1).
// - units 1-5 with racks 6-8 count sequentially, unit fastest.
// - units 6-7 racks 1-8 and units 8-10 racks 4-8 count sequentially.
// - output allowed only while the slot pin is tied to the return.
// - RS485 address built from bay, slot and shelf fields.
// - shelf level decoded into shelves 1 to 10 in 2.5 V steps.
// - alert-response byte matching own address releases the alert.
`timescale 1ns/100ps
`include "rect_ctl_consts.svh"

module rect_restart_ctl #(
	parameter int unsigned GRACE_CYCLES  = `GRACE_CYC,
	parameter int unsigned RETRY_CYCLES  = `RETRY_CYC,
	parameter int unsigned WINDOW_CYCLES = `WINDOW_CYC,
	parameter int unsigned BLINK_CYCLES  = `BLINK_CYC
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   enable_pin_n,
	input  wire logic                   slot_tied,
	input  wire logic                   protocol_rs485,
	input  wire logic [`LVL_BITS-1:0]   unit_position_level,
	input  wire logic [`LVL_BITS-1:0]   rack_position_level,
	input  wire logic [`LVL_BITS-1:0]   slot_position_level,
	input  wire logic [`LVL_BITS-1:0]   shelf_position_level,
	input  wire logic [15:0]            vout_mv,
	input  wire rect_ctl_pkg::fault_in_t faults,
	input  wire logic                   latch_ocp_cfg,
	input  wire logic                   latch_otp_cfg,
	input  wire logic                   status_change,
	input  wire rect_ctl_pkg::bus_req_t  bus_req,
	output logic                        bus_ack,
	output logic                        bus_accept_write,
	output logic                        output_enable,
	output logic                        hiccup,
	output logic                        output_led,
	output logic                        alert_o,
	output logic                        alert_oe,
	output logic                        invalid_cmd,
	output logic                        latched_off,
	output logic [6:0]                  my_address,
	output logic                        addr_valid,
	output logic [11:0]                 rs485_address
);
	// refuse timings the counters cannot serve; the blink counter is only 24 bits wide
	if (GRACE_CYCLES < 2 || RETRY_CYCLES < 2 || WINDOW_CYCLES <= RETRY_CYCLES
	    || BLINK_CYCLES < 2 || BLINK_CYCLES > 32'h00ffffff) begin : g_bad_params
		$error("restart timing parameters out of range");
	end

	// quantise a 0-3.3 V level (full scale 255 = 3.3 V) into ten positions, 0 invalid
	function automatic logic [3:0] quant10(input logic [7:0] lvl);
		logic [3:0] p;
		p = 4'd0;
		if (lvl >= 8'hf1)      p = 4'd0;  // 3.30 V level, invalid
		else if (lvl >= 8'hdb) p = 4'd1;
		else if (lvl >= 8'hc0) p = 4'd2;
		else if (lvl >= 8'ha6) p = 4'd3;
		else if (lvl >= 8'h8b) p = 4'd4;
		else if (lvl >= 8'h71) p = 4'd5;
		else if (lvl >= 8'h56) p = 4'd6;
		else if (lvl >= 8'h3c) p = 4'd7;
		else if (lvl >= 8'h22) p = 4'd8;
		else if (lvl >= 8'h0c) p = 4'd9;
		else                   p = 4'd10;
		return p;
	endfunction

	// rack: eight positions from 3.3 V down to 0 V
	function automatic logic [3:0] quant_rack(input logic [7:0] lvl);
		logic [3:0] p;
		p = 4'd8;
		if (lvl >= 8'hec)      p = 4'd1;
		else if (lvl >= 8'hc1) p = 4'd2;
		else if (lvl >= 8'h9a) p = 4'd3;
		else if (lvl >= 8'h75) p = 4'd4;
		else if (lvl >= 8'h4f) p = 4'd5;
		else if (lvl >= 8'h2e) p = 4'd6;
		else if (lvl >= 8'h0c) p = 4'd7;
		return p;
	endfunction

	logic [3:0] unit_pos;
	logic [3:0] rack_pos;
	logic [3:0] slot_pos;
	logic [3:0] shelf_pos;
	logic [4:0] addr_idx;
	logic       pos_ok;

	// address bits from unit and rack positions
	always_comb begin
		unit_pos  = quant10(unit_position_level);
		rack_pos  = quant_rack(rack_position_level);
		slot_pos  = quant10(slot_position_level);
		// shelf: 25.5 V full scale, 2.5 V per step, mid-point thresholds
		shelf_pos = 4'd0;
		for (int i = 1; i <= 10; i++)
			if (shelf_position_level >= 8'(i * 25 - 12)) shelf_pos = 4'(i);
		addr_idx = 5'd0;
		pos_ok   = 1'b0;
		if (unit_pos >= 4'd1 && unit_pos <= 4'd4 && rack_pos <= 4'd4) begin
			addr_idx = 5'({rack_pos - 4'd1, 2'b00}) + 5'(unit_pos - 4'd1);
			pos_ok   = 1'b1;
		end else if (unit_pos >= 4'd1 && unit_pos <= 4'd5 && rack_pos >= 4'd6) begin
			addr_idx = 5'((rack_pos - 4'd6) * 5) + 5'(unit_pos - 4'd1);
			pos_ok   = 1'b1;
		end else if (unit_pos >= 4'd6 && unit_pos <= 4'd7) begin
			addr_idx = 5'({rack_pos - 4'd1, 1'b0}) + 5'(unit_pos - 4'd6);
			pos_ok   = 1'b1;
		end else if (unit_pos >= 4'd8 && rack_pos >= 4'd4) begin
			addr_idx = 5'((rack_pos - 4'd4) * 3) + 5'(unit_pos - 4'd8);
			pos_ok   = 1'b1;
		end
		if (unit_pos == 4'd0)
			pos_ok = 1'b0;
	end

	rect_ctl_pkg::ctl_state_t s_reg;
	rect_ctl_pkg::ctl_state_t s_next;

	logic en_on;
	logic slot_ok;
	logic rs485;
	logic is_own;
	logic is_bcast;
	logic is_ara;
	logic ara_match;
	logic fault_trip;
	logic latch_fault;

	assign en_on    = ~s_reg.en_sync[1];
	assign slot_ok  = s_reg.slot_sync[1];
	assign rs485    = s_reg.proto_sync[1];
	assign addr_valid = pos_ok && !rs485;
	assign my_address = {`ADDR_UPPER, addr_idx[3:0]};
	assign rs485_address = {slot_pos, shelf_pos, unit_pos};
	assign is_own   = bus_req.valid && addr_valid && bus_req.addr == my_address;
	assign is_bcast = bus_req.valid && bus_req.addr == `ADDR_BCAST;
	assign is_ara   = bus_req.valid && bus_req.addr == `ADDR_ARA && bus_req.rd;
	assign ara_match = is_ara && s_reg.alert && bus_req.ara_byte == my_address;
	// a refused broadcast read gets no acknowledge; an unconfigured unit answers only the alert-response address while its alert is up
	assign bus_ack  = is_own || (is_bcast && !bus_req.rd && addr_valid)
	                  || (is_ara && s_reg.alert);
	assign bus_accept_write = (is_own || is_bcast) && !bus_req.rd && addr_valid;
	assign fault_trip  = faults.ovp || faults.ocp || faults.otp
	                     || (faults.overload && s_reg.grace_done);
	assign latch_fault = (faults.ocp && latch_ocp_cfg) || (faults.otp && latch_otp_cfg);

	// next-state logic of the whole controller
	always_comb begin
		s_next = s_reg;
		s_next.en_sync    = {s_reg.en_sync[0], enable_pin_n};
		s_next.slot_sync  = {s_reg.slot_sync[0], slot_tied};
		s_next.proto_sync = {s_reg.proto_sync[0], protocol_rs485};
		s_next.blink      = (s_reg.blink == 24'(BLINK_CYCLES - 1)) ? 24'h000000
		                    : s_reg.blink + 24'h000001;
		if (s_reg.blink == 24'(BLINK_CYCLES - 1))
			s_next.led = ~s_reg.led;
		// bus operation command tracking
		if (bus_accept_write && bus_req.op_write) begin
			s_next.op_on = bus_req.op_on;
			if (!bus_req.op_on)
				s_next.op_was_off = 1'b1;
		end
		if (!en_on)
			s_next.en_was_off = 1'b1;
		// overvoltage window runs once the first trip has been counted
		if (s_reg.ov_count != 2'd0) begin
			if (s_reg.window == 32'd0)
				s_next.ov_count = 2'd0;
			else
				s_next.window = s_reg.window - 32'd1;
		end
		if (s_reg.timer != 32'd0)
			s_next.timer = s_reg.timer - 32'd1;
		case (s_reg.state)
			rect_ctl_pkg::ST_OFF: begin
				s_next.grace_done = 1'b0;
				if (en_on && s_reg.op_on && slot_ok) begin
					s_next.state = rect_ctl_pkg::ST_ON;
					s_next.timer = GRACE_CYCLES;
				end
			end
			rect_ctl_pkg::ST_ON: begin
				if (s_reg.timer == 32'd1)
					s_next.grace_done = 1'b1;
				if (!en_on || !s_reg.op_on || !slot_ok) begin
					s_next.state = rect_ctl_pkg::ST_OFF;
				end else if (fault_trip) begin
					s_next.grace_done = 1'b1;
					if (faults.ovp) begin
						s_next.ov_count = s_reg.ov_count + 2'd1;
						if (s_reg.ov_count == 2'd0)
							s_next.window = WINDOW_CYCLES;
						if (s_reg.ov_count == `OV_LIMIT - 2'd1)
							s_next.state = rect_ctl_pkg::ST_LATCHED;
						else begin
							s_next.state = rect_ctl_pkg::ST_WAIT;
							s_next.timer = RETRY_CYCLES;
						end
					end else if (latch_fault) begin
						s_next.state = rect_ctl_pkg::ST_LATCHED;
					end else if (faults.in_limit && vout_mv < `LOW_VOUT_MV) begin
						s_next.state = rect_ctl_pkg::ST_HICCUP;
						s_next.timer = RETRY_CYCLES;
					end else if (!faults.in_limit) begin
						s_next.state = rect_ctl_pkg::ST_WAIT;
						s_next.timer = RETRY_CYCLES;
					end
				end
			end
			rect_ctl_pkg::ST_WAIT,
			rect_ctl_pkg::ST_HICCUP: begin
				// an enable lost during the wait must not flash the output on for a cycle
				if (!en_on || !s_reg.op_on || !slot_ok)
					s_next.state = rect_ctl_pkg::ST_OFF;
				else if (s_reg.timer == 32'd0)
					s_next.state = rect_ctl_pkg::ST_ON;
			end
			rect_ctl_pkg::ST_LATCHED: begin
				// release by pin or command cycled off then on
				if ((s_reg.en_was_off && en_on) || (s_reg.op_was_off && s_reg.op_on)) begin
					s_next.state    = rect_ctl_pkg::ST_OFF;
					s_next.ov_count = 2'd0;
				end
			end
			default: s_next.state = rect_ctl_pkg::ST_OFF;
		endcase
		if (s_reg.state != rect_ctl_pkg::ST_LATCHED) begin
			s_next.en_was_off = 1'b0;
			s_next.op_was_off = 1'b0;
		end
		// refused broadcast read; set wins over nothing else clearing it
		if (is_bcast && bus_req.rd)
			s_next.invalid_cmd = 1'b1;
		// alert: a new status change wins over a same-cycle response release
		if (ara_match)
			s_next.alert = 1'b0;
		if (status_change || (fault_trip && s_reg.state == rect_ctl_pkg::ST_ON))
			s_next.alert = 1'b1;
	end

	// state register; outputs off and controller idle after bias power-up
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{state: rect_ctl_pkg::ST_OFF, op_on: 1'b1, en_sync: 2'b11, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign output_enable = s_reg.state == rect_ctl_pkg::ST_ON;
	assign hiccup        = s_reg.state == rect_ctl_pkg::ST_HICCUP;
	assign latched_off   = s_reg.state == rect_ctl_pkg::ST_LATCHED;
	assign invalid_cmd   = s_reg.invalid_cmd;
	assign alert_o       = 1'b0;
	assign alert_oe      = s_reg.alert; // open drain, pulled low while asserted
	// indicator blinks in limit above 10 V, steady on, dark otherwise
	assign output_led    = output_enable && ((faults.in_limit && vout_mv >= `LOW_VOUT_MV)
	                       ? s_reg.led : 1'b1);

	latched_dark_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		latched_off |-> !output_led) else $error("indicator lit while latched");
	slot_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(output_enable) |-> $past(slot_ok)) else $error("output on without slot");
	bcast_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(is_bcast && bus_req.rd) |-> !bus_accept_write ##1 invalid_cmd)
		else $error("broadcast read not refused");
	addr_form_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		addr_valid |-> my_address[6:4] == 3'b100) else $error("bad address upper bits");
	bad_pos_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(unit_pos == 4'd0 && bus_req.addr != `ADDR_ARA) |-> !bus_ack)
		else $error("acknowledged with invalid position");
	alert_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		status_change |=> alert_oe) else $error("alert not raised");
	ara_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ara_match && !status_change && !fault_trip) |=> !alert_oe)
		else $error("alert not released");
	sequence ov_third_s;
		output_enable && faults.ovp && !latch_fault && s_reg.ov_count == 2'd2
		&& en_on && s_reg.op_on && slot_ok;
	endsequence
	ov_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ov_third_s |=> latched_off) else $error("third overvoltage did not latch");
	latch_cfg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(output_enable && en_on && s_reg.op_on && slot_ok && !faults.ovp
		 && faults.ocp && latch_ocp_cfg) |=> latched_off) else $error("ocp latch missed");
	hiccup_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(output_enable && en_on && s_reg.op_on && slot_ok && !faults.ovp && !latch_fault
		 && (faults.ocp || faults.otp) && faults.in_limit && vout_mv < `LOW_VOUT_MV) |=> hiccup)
		else $error("limit below 10 V did not hiccup");
endmodule

// [testbench/host_master_model.sv]
// host bus master model that issues one transaction summary at a time
`timescale 1ns/100ps
module host_master_model (
	input  wire logic              clk_sys,
	input  wire logic              bus_ack,
	input  wire logic              bus_accept_write,
	output rect_ctl_pkg::bus_req_t bus_req
);
	logic ack_seen;
	logic acc_seen;

	initial bus_req = '0;

	// request held up to the edge that takes it; answer sampled at that same edge
	task automatic issue(input logic [6:0] a, input logic rd, input logic opw,
		input logic opon, input logic [6:0] ara);
		rect_ctl_pkg::bus_req_t r;
		r = '{1'b1, a, rd, opw, opon, ara};
		bus_req <= r;
		@(posedge clk_sys);
		ack_seen = bus_ack;
		acc_seen = bus_accept_write;
		// released fields inverted so stale values never pass for a request
		r = ~r;
		r.valid = 1'b0;
		bus_req <= r;
	endtask
endmodule

// [testbench/rectifier_address_and_restart_ctl_tb.sv]
// self-checking bench for the restart, address and alert controller
`timescale 1ns/100ps
module rectifier_address_and_restart_ctl_tb;
	localparam int G = 20;
	localparam int R = 10;
	localparam int W = 100;
	localparam int B = 8;
	logic                    clk_sys;
	logic                    rst_n;
	logic                    enable_pin_n;
	logic                    slot_tied;
	logic                    protocol_rs485;
	logic [7:0]              unit_position_level;
	logic [7:0]              rack_position_level;
	logic [7:0]              slot_position_level;
	logic [7:0]              shelf_position_level;
	logic [15:0]             vout_mv;
	rect_ctl_pkg::fault_in_t faults;
	logic                    latch_ocp_cfg;
	logic                    latch_otp_cfg;
	logic                    status_change;
	rect_ctl_pkg::bus_req_t  bus_req;
	logic                    bus_ack;
	logic                    bus_accept_write;
	logic                    output_enable;
	logic                    hiccup;
	logic                    output_led;
	logic                    alert_o;
	logic                    alert_oe;
	logic                    invalid_cmd;
	logic                    latched_off;
	logic [6:0]              my_address;
	logic                    addr_valid;
	logic [11:0]             rs485_address;
	int                      err_total;
	int                      n_tests;
	logic [4:0]              e;
	logic                    led_a;
	// adc codes of the nominal position levels, 255 standing for 3.3 V
	logic [7:0] ucode [10] = '{8'he8, 8'hce, 8'hb5, 8'h9b, 8'h82, 8'h68, 8'h4f, 8'h35,
		8'h1c, 8'h00};
	logic [7:0] rcode [8] = '{8'hff, 8'hd8, 8'hb2, 8'h8b, 8'h6c, 8'h4d, 8'h27, 8'h00};

	rect_restart_ctl #(.GRACE_CYCLES(G), .RETRY_CYCLES(R), .WINDOW_CYCLES(W),
		.BLINK_CYCLES(B)) u_rect_restart_ctl (
		.clk_sys(clk_sys), .rst_n(rst_n), .enable_pin_n(enable_pin_n), .slot_tied(slot_tied),
		.protocol_rs485(protocol_rs485), .unit_position_level(unit_position_level),
		.rack_position_level(rack_position_level), .slot_position_level(slot_position_level),
		.shelf_position_level(shelf_position_level), .vout_mv(vout_mv), .faults(faults),
		.latch_ocp_cfg(latch_ocp_cfg), .latch_otp_cfg(latch_otp_cfg),
		.status_change(status_change), .bus_req(bus_req), .bus_ack(bus_ack),
		.bus_accept_write(bus_accept_write), .output_enable(output_enable), .hiccup(hiccup),
		.output_led(output_led), .alert_o(alert_o), .alert_oe(alert_oe),
		.invalid_cmd(invalid_cmd), .latched_off(latched_off), .my_address(my_address),
		.addr_valid(addr_valid), .rs485_address(rs485_address));

	host_master_model u_host_master_model (.clk_sys(clk_sys), .bus_ack(bus_ack),
		.bus_accept_write(bus_accept_write), .bus_req(bus_req));

	// expected {valid, position bits} of a unit and rack pair
	function automatic logic [4:0] expa(input int u, input int r);
		if (u <= 4 && r <= 4) return 5'h10 | 5'((r - 1) * 4 + u - 1);
		if (u <= 5 && r >= 6) return 5'h10 | 5'((r - 6) * 5 + u - 1);
		if (u >= 6 && u <= 7) return 5'h10 | 5'((r - 1) * 2 + u - 6);
		if (u >= 8 && r >= 4) return 5'h10 | 5'((r - 4) * 3 + u - 8);
		return 5'h00;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// bounded wait; a hang shows up as a failed compare afterwards
	task automatic wait_oe(input logic v);
		for (int i = 0; i < 40 && output_enable !== v; i++) @(posedge clk_sys);
	endtask

	task automatic bw(input logic [6:0] a, input logic rd, input logic opw, input logic opon,
		input logic [6:0] ara, input logic eack, input logic eacc);
		u_host_master_model.issue(a, rd, opw, opon, ara);
		chk(u_host_master_model.ack_seen, eack);
		chk(u_host_master_model.acc_seen, eacc);
		wt(1);
	endtask

	task automatic pulse(input rect_ctl_pkg::fault_in_t f);
		faults <= f;
		wt(1);
		faults <= '0;
		wt(1);
	endtask

	// off long enough for the synchroniser, then on again
	task automatic cycle_en;
		enable_pin_n <= 1'b1;
		wt(4);
		enable_pin_n <= 1'b0;
		wait_oe(1'b1);
		chk(output_enable, 1'b1);
	endtask

	task automatic ov_retry;
		pulse(5'h10);
		chk(output_enable, 1'b0);
		wt(R - 4);
		chk(output_enable, 1'b0);
		wait_oe(1'b1);
		chk(output_enable, 1'b1);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// a hang is cut short well past the longest expected run
	initial begin
		#(50 * 30000);
		err_total++;
		print_verdict;
	end

	initial begin
		err_total = 0;
		n_tests = 0;
		rst_n = 1'b0;
		enable_pin_n = 1'b1;
		slot_tied = 1'b1;
		protocol_rs485 = 1'b0;
		unit_position_level = ucode[0];
		rack_position_level = rcode[0];
		slot_position_level = ucode[0];
		shelf_position_level = 8'h19;
		vout_mv = 16'hc350;
		faults = 5'h01;
		latch_ocp_cfg = 1'b0;
		latch_otp_cfg = 1'b0;
		status_change = 1'b0;
		wt(4);
		rst_n <= 1'b1;
		wt(2);
		// overload present from power-up rides through the grace span
		enable_pin_n <= 1'b0;
		wait_oe(1'b1);
		wt(10);
		chk(output_enable, 1'b1);
		wt(12);
		chk(output_enable, 1'b0);
		faults <= '0;
		wait_oe(1'b1);
		chk(output_led, 1'b1);
		ov_retry();
		ov_retry();
		pulse(5'h10);
		wt(2 * R);
		chk(latched_off, 1'b1);
		chk(output_enable, 1'b0);
		chk(output_led, 1'b0);
		cycle_en();
		chk(output_enable, 1'b1);
		chk(latched_off, 1'b0);
		ov_retry();
		ov_retry();
		wt(W + 10);
		ov_retry();
		ov_retry();
		chk(latched_off, 1'b0);
		pulse(5'h10);
		wt(2 * R);
		chk(latched_off, 1'b1);
		bw(7'h40, 1'b0, 1'b1, 1'b0, 7'h00, 1'b1, 1'b1);
		bw(7'h40, 1'b0, 1'b1, 1'b1, 7'h00, 1'b1, 1'b1);
		wait_oe(1'b1);
		chk(output_enable, 1'b1);
		// limit above 10 V: indicator toggles once per blink span
		faults <= 5'h02;
		wt(1);
		led_a = output_led;
		wt(B);
		chk(output_led, !led_a);
		wt(B);
		chk(output_led, led_a);
		// limit below 10 V on a restartable fault: hiccup, then back on
		vout_mv <= 16'h1388;
		pulse(5'h0a);
		chk(hiccup, 1'b1);
		chk(output_enable, 1'b0);
		wait_oe(1'b1);
		chk(hiccup, 1'b0);
		vout_mv <= 16'hc350;
		// auto restart versus configured latch-off for overcurrent and overtemperature
		for (int k = 0; k < 4; k++) begin
			latch_ocp_cfg <= k[1];
			latch_otp_cfg <= k[1];
			wt(1);
			pulse(k[0] ? 5'h04 : 5'h08);
			wt(2 * R);
			chk(latched_off, k[1]);
			chk(output_enable, !k[1]);
			cycle_en();
		end
		slot_tied <= 1'b0;
		wt(4);
		chk(output_enable, 1'b0);
		slot_tied <= 1'b1;
		wait_oe(1'b1);
		chk(output_enable, 1'b1);
		bw(7'h40, 1'b0, 1'b0, 1'b0, 7'h00, 1'b1, 1'b1);
		bw(7'h40, 1'b1, 1'b0, 1'b0, 7'h00, 1'b1, 1'b0);
		bw(7'h41, 1'b0, 1'b0, 1'b0, 7'h00, 1'b0, 1'b0);
		bw(7'h00, 1'b0, 1'b0, 1'b0, 7'h00, 1'b1, 1'b1);
		chk(invalid_cmd, 1'b0);
		bw(7'h00, 1'b1, 1'b0, 1'b0, 7'h00, 1'b0, 1'b0);
		chk(invalid_cmd, 1'b1);
		bw(7'h00, 1'b0, 1'b1, 1'b0, 7'h00, 1'b1, 1'b1);
		wt(G);
		chk(output_enable, 1'b0);
		bw(7'h00, 1'b0, 1'b1, 1'b1, 7'h00, 1'b1, 1'b1);
		wait_oe(1'b1);
		chk(output_enable, 1'b1);
		bw(7'h40, 1'b1, 1'b0, 1'b0, 7'h00, 1'b1, 1'b0);
		// alert is still up from the earlier trips; release it before the status pulse
		bw(7'h0c, 1'b1, 1'b0, 1'b0, 7'h40, 1'b1, 1'b0);
		chk(alert_oe, 1'b0);
		status_change <= 1'b1;
		wt(1);
		status_change <= 1'b0;
		wt(1);
		chk({alert_oe, alert_o}, 2'b10);
		bw(7'h0c, 1'b1, 1'b0, 1'b0, 7'h41, 1'b1, 1'b0);
		chk(alert_oe, 1'b1);
		bw(7'h0c, 1'b1, 1'b0, 1'b0, 7'h40, 1'b1, 1'b0);
		chk(alert_oe, 1'b0);
		// every unit and rack pair, undefined pairs claiming nothing
		for (int u = 1; u <= 10; u++) begin
			for (int r = 1; r <= 8; r++) begin
				unit_position_level <= ucode[u - 1];
				rack_position_level <= rcode[r - 1];
				wt(2);
				e = expa(u, r);
				chk(addr_valid, e[4]);
				if (e[4]) chk(my_address, {3'b100, e[3:0]});
			end
		end
		unit_position_level <= 8'hff;
		rack_position_level <= rcode[0];
		wt(2);
		chk(addr_valid, 1'b0);
		bw(7'h40, 1'b0, 1'b0, 1'b0, 7'h00, 1'b0, 1'b0);
		unit_position_level <= ucode[2];
		slot_position_level <= ucode[4];
		shelf_position_level <= 8'h4b;
		protocol_rs485 <= 1'b1;
		wt(4);
		chk(rs485_address, 12'h533);
		bw(7'h42, 1'b0, 1'b0, 1'b0, 7'h00, 1'b0, 1'b0);
		protocol_rs485 <= 1'b0;
		wt(4);
		bw(7'h42, 1'b0, 1'b0, 1'b0, 7'h00, 1'b1, 1'b1);
		// mid-run bias reset clears the sticky flag and restarts with output allowed
		rst_n <= 1'b0;
		wt(2);
		chk(invalid_cmd, 1'b0);
		chk(output_led, 1'b0);
		rst_n <= 1'b1;
		wait_oe(1'b1);
		chk(output_led, 1'b1);
		print_verdict;
	end
endmodule
